// File: include/cbtrf_pkg.sv
// Purpose: Shared constants for the CAN timing, receive FIFO and filter block
// Assumes: 32-bit AXI4-Lite register words, 8-bit byte addresses
// Notes:   Register offsets are byte addresses
package cbtrf_pkg;
  // ===========================================================
  // Sizes
  localparam int ID_W = 29;
  localparam int NUM_BUF = 8;
  localparam int NUM_PROG = 6;
  localparam int NUM_FILT = 6;
  localparam logic [3:0] DEDICATED_BUFS = 4'h2;
  // ===========================================================
  // Register offsets
  localparam logic [7:0] OFS_TIMING_A = 8'h00;
  localparam logic [7:0] OFS_TIMING_C = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_BUF_DIR = 8'h10;
  localparam logic [7:0] OFS_FILT_EN = 8'h14;
  localparam logic [7:0] OFS_FULL = 8'h18;
  localparam logic [7:0] OFS_READ_ID = 8'h1C;
  localparam logic [7:0] OFS_FILTER0 = 8'h20;
  localparam logic [7:0] OFS_MASK0 = 8'h40;
  localparam logic [7:0] OFS_TIMING_Q = 8'h48;
  localparam logic [7:0] OFS_IO_CTRL = 8'h4C;
  // ===========================================================
  // Reset values and field layout
  localparam logic [7:0] RST_TIMING_A = 8'h00;
  localparam logic [7:0] RST_TIMING_C = 8'h00;
  localparam logic [7:0] TIMING_C_MASK = 8'hC7;
  localparam int WAKE_DIS_BIT = 7;
  localparam int WAKE_FILT_BIT = 6;
  localparam int CAP_SRC_BIT = 4;
  localparam logic [3:0] CAP_MODE_CAN = 4'h3;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [4:0] ICODE_FIFO = 5'h10;
  localparam logic [4:0] ICODE_NONE = 5'h00;
  localparam logic [3:0] HWM_FREE_ONE = 4'h1;
  localparam logic [3:0] HWM_FREE_FOUR = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ===========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_FILT_NS = 200;
  localparam int WAKE_FILT_CYC =
    (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cbtrf_pkg

// File: rtl/cbtrf_id_match.sv
// Purpose: One acceptance filter compare against a masked identifier
// Assumes: Mask bit set means the bit is examined
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module cbtrf_id_match #(
  parameter int ID_W = 29
) (
  input wire logic [ID_W-1:0] id,
  input wire logic [ID_W-1:0] filter,
  input wire logic [ID_W-1:0] mask,
  output logic match
);
  // Every bit must accept for the filter to hit
  assign match = &(~mask | ~(filter ^ id));
endmodule : cbtrf_id_match
`default_nettype wire

// File: rtl/cbtrf_core.sv
// Purpose: CAN bit-timing fields, receive FIFO, filters, wake and capture
// Assumes: Message arrives from the assembly buffer on aclk, one pulse
// Notes:   Registers on AXI4-Lite; can_rx is a raw pin
`timescale 1ns/10ps
`default_nettype none
module cbtrf_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic msg_valid,
  input wire logic [cbtrf_pkg::ID_W-1:0] msg_id,
  input wire logic can_rx,
  output logic msg_stored,
  output logic [2:0] store_index,
  output logic capture_trigger,
  output logic high_water_event,
  output logic wake_event,
  output logic quantum_tick,
  output logic [2:0] jump_width_quanta,
  output logic [7:0] quantum_clocks,
  output logic [3:0] phase_two_quanta
);
  localparam int IW = cbtrf_pkg::ID_W;
  localparam int NF = cbtrf_pkg::NUM_FILT;
  localparam int NB = cbtrf_pkg::NUM_BUF;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] bit_timing_ctrl_a;
    logic [7:0] bit_timing_ctrl_c;
    logic config_mode;
    logic [1:0] op_mode;
    logic phase_two_source_select;
    logic high_water_select;
    logic [4:0] io_control_reg;
    logic [5:0] prog_tx;
    logic [5:0] filt_en;
    logic [7:0] buffer_full_flag;
    logic [7:0][IW-1:0] ids;
    logic [5:0][IW-1:0] filt;
    logic [1:0][IW-1:0] mask;
    logic [2:0] fifo_write_pointer;
    logic [2:0] fifo_read_pointer;
    logic [4:0] interrupt_code;
    logic msg_stored;
    logic [2:0] store_index;
    logic capture_trigger;
    logic high_water_event;
    logic rx_s1;
    logic rx_s2;
    logic wake_lvl;
    logic [3:0] wake_cnt;
    logic wake_event;
    logic [6:0] quantum_cnt;
    logic quantum_tick;
    logic [2:0] jump_width_quanta;
    logic [7:0] quantum_clocks;
    logic [3:0] phase_two_quanta;
  } cbtrf_state_t;

  localparam cbtrf_state_t ST_RESET = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    rx_s1: 1'b1, rx_s2: 1'b1, wake_lvl: 1'b1,
    bit_timing_ctrl_a: cbtrf_pkg::RST_TIMING_A,
    bit_timing_ctrl_c: cbtrf_pkg::RST_TIMING_C,
    default: '0};

  cbtrf_state_t st;
  cbtrf_state_t next_st;
  logic [NF-1:0] match;
  logic [NF-1:0] en_match;
  logic [31:0] wv;
  logic [31:0] tmp;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_hit;
  logic [7:0] clr;
  logic [7:0] set_bits;
  logic take;
  logic [2:0] idx;
  logic [3:0] depth;
  logic [3:0] occ;
  logic [3:0] free;
  logic [3:0] thr;
  logic [3:0] p4;
  logic run;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{strb[b]}};
    end
    return (old & ~m) | (data & m);
  endfunction : merge_lanes

  // ===========================================================
  // Filter bank; the first two filters share the first mask
  for (genvar g = 0; g < NF; g++) begin : g_filt
    cbtrf_id_match #(.ID_W(IW)) u_match (
      .id(msg_id),
      .filter(st.filt[g]),
      .mask(st.mask[(g < 2) ? 0 : 1]),
      .match(match[g])
    );
  end
  assign en_match = match & st.filt_en;

  // ===========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.msg_stored = 1'b0;
    next_st.capture_trigger = 1'b0;
    next_st.high_water_event = 1'b0;
    wv = 32'h0000_0000;
    tmp = 32'h0000_0000;
    wr_hit = 1'b0;
    clr = 8'h00;
    take = 1'b0;
    idx = 3'h0;
    // FIFO length stops at the first programmable transmit buffer
    depth = cbtrf_pkg::DEDICATED_BUFS;
    run = 1'b1;
    for (int i = 0; i < cbtrf_pkg::NUM_PROG; i++) begin
      if (run && !st.prog_tx[i]) begin
        depth = depth + 4'h1;
      end else begin
        run = 1'b0;
      end
    end
    occ = 4'h0;
    for (int i = 0; i < NB; i++) begin
      if (4'(i) < depth) begin
        occ = occ + {3'h0, st.buffer_full_flag[i]};
      end
    end
    free = depth - occ;
    thr = st.high_water_select ? cbtrf_pkg::HWM_FREE_FOUR
                               : cbtrf_pkg::HWM_FREE_ONE;
    // Read decode
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    case (araddr)
      cbtrf_pkg::OFS_TIMING_A: rd_data = {24'h0, st.bit_timing_ctrl_a};
      cbtrf_pkg::OFS_TIMING_C: rd_data = {24'h0, st.bit_timing_ctrl_c};
      cbtrf_pkg::OFS_CONTROL: rd_data = {12'h000, 1'b0,
          st.fifo_read_pointer, 11'h000, st.high_water_select,
          st.phase_two_source_select, st.op_mode, st.config_mode};
      cbtrf_pkg::OFS_STATUS: rd_data = {12'h000, 1'b0,
          st.fifo_write_pointer, 3'h0, depth,
          ~st.buffer_full_flag[st.fifo_read_pointer],
          3'h0, st.interrupt_code};
      cbtrf_pkg::OFS_BUF_DIR: rd_data = {26'h0, st.prog_tx};
      cbtrf_pkg::OFS_FILT_EN: rd_data = {26'h0, st.filt_en};
      cbtrf_pkg::OFS_FULL: rd_data = {24'h0, st.buffer_full_flag};
      cbtrf_pkg::OFS_READ_ID: rd_data = 32'(st.ids[st.fifo_read_pointer]);
      cbtrf_pkg::OFS_TIMING_Q: rd_data = {16'h0000, st.phase_two_quanta,
          st.quantum_clocks, 1'b0, st.jump_width_quanta};
      cbtrf_pkg::OFS_IO_CTRL: rd_data = {27'h0, st.io_control_reg};
      default: begin
        rd_ok = 1'b0;
        for (int i = 0; i < NF; i++) begin
          if (araddr == cbtrf_pkg::OFS_FILTER0 + 8'(4 * i)) begin
            rd_data = 32'(st.filt[i]);
            rd_ok = 1'b1;
          end
        end
        for (int i = 0; i < 2; i++) begin
          if (araddr == cbtrf_pkg::OFS_MASK0 + 8'(4 * i)) begin
            rd_data = 32'(st.mask[i]);
            rd_ok = 1'b1;
          end
        end
      end
    endcase
    // ===========================================================
    // AXI4-Lite write: address and data taken in either order
    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
      next_st.awready = 1'b0;
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = cbtrf_pkg::RESP_OKAY;
      case (st.aw_addr)
        cbtrf_pkg::OFS_TIMING_A: begin
          wv = merge_lanes({24'h0, st.bit_timing_ctrl_a},
                           st.w_data, st.w_strb);
          if (st.config_mode) begin
            next_st.bit_timing_ctrl_a = wv[7:0];
          end
        end
        cbtrf_pkg::OFS_TIMING_C: begin
          wv = merge_lanes({24'h0, st.bit_timing_ctrl_c},
                           st.w_data, st.w_strb);
          if (st.config_mode) begin
            next_st.bit_timing_ctrl_c = wv[7:0] & cbtrf_pkg::TIMING_C_MASK;
          end
        end
        cbtrf_pkg::OFS_CONTROL: begin
          wv = merge_lanes({27'h0, st.high_water_select,
              st.phase_two_source_select, st.op_mode, st.config_mode},
              st.w_data, st.w_strb);
          next_st.config_mode = wv[0];
          next_st.op_mode = wv[2:1];
          next_st.phase_two_source_select = wv[3];
          next_st.high_water_select = wv[4];
        end
        cbtrf_pkg::OFS_IO_CTRL: begin
          wv = merge_lanes({27'h0, st.io_control_reg}, st.w_data, st.w_strb);
          next_st.io_control_reg = wv[4:0];
        end
        cbtrf_pkg::OFS_BUF_DIR: begin
          wv = merge_lanes({26'h0, st.prog_tx}, st.w_data, st.w_strb);
          next_st.prog_tx = wv[5:0];
        end
        cbtrf_pkg::OFS_FILT_EN: begin
          wv = merge_lanes({26'h0, st.filt_en}, st.w_data, st.w_strb);
          next_st.filt_en = wv[5:0];
        end
        // Write one to release a buffer
        cbtrf_pkg::OFS_FULL: clr = st.w_data[7:0] & {8{st.w_strb[0]}};
        cbtrf_pkg::OFS_STATUS, cbtrf_pkg::OFS_READ_ID,
        cbtrf_pkg::OFS_TIMING_Q: wr_hit = 1'b1;
        default: begin
          for (int i = 0; i < NF; i++) begin
            if (st.aw_addr == cbtrf_pkg::OFS_FILTER0 + 8'(4 * i)) begin
              tmp = merge_lanes(32'(st.filt[i]), st.w_data, st.w_strb);
              next_st.filt[i] = tmp[IW-1:0];
              wr_hit = 1'b1;
            end
          end
          for (int i = 0; i < 2; i++) begin
            if (st.aw_addr == cbtrf_pkg::OFS_MASK0 + 8'(4 * i)) begin
              tmp = merge_lanes(32'(st.mask[i]), st.w_data, st.w_strb);
              next_st.mask[i] = tmp[IW-1:0];
              wr_hit = 1'b1;
            end
          end
          if (!wr_hit) begin
            next_st.bresp = cbtrf_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // AXI4-Lite read
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = rd_ok ? cbtrf_pkg::RESP_OKAY : cbtrf_pkg::RESP_SLVERR;
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    // ===========================================================
    // Acceptance and storage
    if (msg_valid) begin
      if (st.op_mode == cbtrf_pkg::MODE_FIFO) begin
        // A full slot at the write pointer means the FIFO is full
        if ((|en_match) && !st.buffer_full_flag[st.fifo_write_pointer]) begin
          take = 1'b1;
          idx = st.fifo_write_pointer;
        end
      end else if ((|en_match[1:0]) && !st.buffer_full_flag[0]) begin
        take = 1'b1;
        idx = 3'h0;
      end else if ((|en_match[5:2]) && !st.buffer_full_flag[1]) begin
        take = 1'b1;
        idx = 3'h1;
      end
    end
    set_bits = take ? 8'(8'h01 << idx) : 8'h00;
    // A new message wins over a release of the same slot
    next_st.buffer_full_flag = (st.buffer_full_flag & ~clr) | set_bits;
    p4 = {1'b0, st.fifo_write_pointer} + 4'h1;
    if (take) begin
      next_st.ids[idx] = msg_id;
      next_st.msg_stored = 1'b1;
      next_st.store_index = idx;
      next_st.capture_trigger = st.io_control_reg[cbtrf_pkg::CAP_SRC_BIT]
          && (st.io_control_reg[3:0] == cbtrf_pkg::CAP_MODE_CAN);
      if (st.op_mode == cbtrf_pkg::MODE_FIFO) begin
        next_st.fifo_write_pointer = (p4 >= depth) ? 3'h0 : p4[2:0];
        next_st.interrupt_code = cbtrf_pkg::ICODE_FIFO;
        next_st.high_water_event = (free - 4'h1) == thr;
      end
    end else if (!st.buffer_full_flag[st.fifo_read_pointer]) begin
      next_st.interrupt_code = cbtrf_pkg::ICODE_NONE;
    end
    p4 = {1'b0, st.fifo_read_pointer} + 4'h1;
    if (st.op_mode == cbtrf_pkg::MODE_FIFO
        && clr[st.fifo_read_pointer]
        && st.buffer_full_flag[st.fifo_read_pointer]) begin
      next_st.fifo_read_pointer = (p4 >= depth) ? 3'h0 : p4[2:0];
    end
    // Configuration mode restarts the ring at buffer zero
    if (st.config_mode) begin
      next_st.fifo_write_pointer = 3'h0;
      next_st.fifo_read_pointer = 3'h0;
    end
    // ===========================================================
    // Bit timing
    next_st.jump_width_quanta = {1'b0, st.bit_timing_ctrl_a[7:6]} + 3'h1;
    next_st.quantum_clocks = {1'b0, st.bit_timing_ctrl_a[5:0], 1'b0} + 8'h02;
    next_st.phase_two_quanta = st.phase_two_source_select
        ? {1'b0, st.bit_timing_ctrl_c[2:0]} + 4'h1 : 4'h0;
    next_st.quantum_tick = 1'b0;
    if (st.quantum_cnt >= {st.bit_timing_ctrl_a[5:0], 1'b1}) begin
      next_st.quantum_cnt = 7'h00;
      next_st.quantum_tick = 1'b1;
    end else begin
      next_st.quantum_cnt = st.quantum_cnt + 7'h01;
    end
    // ===========================================================
    // Wake-up on dominant edge of the bus line
    next_st.rx_s1 = can_rx;
    next_st.rx_s2 = st.rx_s1;
    if (!st.bit_timing_ctrl_c[cbtrf_pkg::WAKE_FILT_BIT]) begin
      next_st.wake_lvl = st.rx_s2;
      next_st.wake_cnt = 4'h0;
    end else if (st.rx_s2 != st.wake_lvl) begin
      // Short pulses never reach the wake detector
      if (st.wake_cnt == 4'(cbtrf_pkg::WAKE_FILT_CYC - 1)) begin
        next_st.wake_lvl = st.rx_s2;
        next_st.wake_cnt = 4'h0;
      end else begin
        next_st.wake_cnt = st.wake_cnt + 4'h1;
      end
    end else begin
      next_st.wake_cnt = 4'h0;
    end
    next_st.wake_event = st.wake_lvl && !next_st.wake_lvl
        && !st.bit_timing_ctrl_c[cbtrf_pkg::WAKE_DIS_BIT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign msg_stored = st.msg_stored;
  assign store_index = st.store_index;
  assign capture_trigger = st.capture_trigger;
  assign high_water_event = st.high_water_event;
  assign wake_event = st.wake_event;
  assign quantum_tick = st.quantum_tick;
  assign jump_width_quanta = st.jump_width_quanta;
  assign quantum_clocks = st.quantum_clocks;
  assign phase_two_quanta = st.phase_two_quanta;

  // ===========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_fifo_take;
    take && st.op_mode == cbtrf_pkg::MODE_FIFO && !st.config_mode;
  endsequence
  sequence s_fifo_pop;
    st.op_mode == cbtrf_pkg::MODE_FIFO && !st.config_mode
      && clr[st.fifo_read_pointer]
      && st.buffer_full_flag[st.fifo_read_pointer];
  endsequence

  // Derived outputs lag the field by one edge; jump width and quantum clocks are zero only until the first edge out of reset
  AST_JUMP_WIDTH: assert property ($past(aresetn)
    && $stable(st.bit_timing_ctrl_a) |->
    jump_width_quanta == {1'b0, st.bit_timing_ctrl_a[7:6]} + 3'h1)
    else $error("jump width does not follow field");
  AST_QUANTUM: assert property ((quantum_tick
    && st.bit_timing_ctrl_a[5:0] == 6'h00) ##1 $stable(st.bit_timing_ctrl_a)
    |=> quantum_tick)
    else $error("quantum not two clocks at prescaler zero");
  AST_PHASE_TWO: assert property (!st.phase_two_source_select |=>
    phase_two_quanta == 4'h0)
    else $error("phase two field used while ignored");
  AST_DEPTH: assert property (st.prog_tx[0] |-> depth == 4'h2)
    else $error("depth wrong with first buffer transmitting");
  AST_ACCEPT: assert property (take |-> (|en_match))
    else $error("message stored without enabled match");
  AST_LEGACY: assert property (take && st.op_mode != cbtrf_pkg::MODE_FIFO
    && idx == 3'h1 |-> (|en_match[5:2]) && !(|en_match[1:0]))
    else $error("wrong buffer for legacy filter group");
  AST_STORE: assert property (s_fifo_take |=> msg_stored
    && st.buffer_full_flag[st.store_index] && st.fifo_write_pointer
    != $past(st.fifo_write_pointer))
    else $error("store did not fill slot or advance pointer");
  AST_CODE: assert property (s_fifo_take |=>
    st.interrupt_code == cbtrf_pkg::ICODE_FIFO)
    else $error("interrupt code not set on FIFO receive");
  AST_POP: assert property (s_fifo_pop |=>
    st.fifo_read_pointer != $past(st.fifo_read_pointer))
    else $error("read pointer did not advance on release");
  AST_NO_OVER: assert property (msg_valid
    && st.op_mode == cbtrf_pkg::MODE_FIFO
    && st.buffer_full_flag[st.fifo_write_pointer] |-> !take)
    else $error("stored into an occupied slot");
  AST_HIGH_WATER: assert property (high_water_event |->
    $past(free) == $past(thr) + 4'h1)
    else $error("high water event at wrong fill level");
  AST_CAPTURE: assert property (take |=> capture_trigger
    == ($past(st.io_control_reg) == {1'b1, cbtrf_pkg::CAP_MODE_CAN}))
    else $error("capture pulse does not match enable");
  AST_CFG_LOCK: assert property (!st.config_mode |=>
    $stable(st.bit_timing_ctrl_a) && $stable(st.bit_timing_ctrl_c))
    else $error("timing register changed outside configuration");
  AST_WAKE_OFF: assert property (
    st.bit_timing_ctrl_c[cbtrf_pkg::WAKE_DIS_BIT] |=> !wake_event)
    else $error("wake event while disabled");
endmodule : cbtrf_core
`default_nettype wire

// File: verification/cbtrf_msg_src.sv
// Purpose: Assembled message source and bus line beside the block
// Assumes: One message per send call, aligned to aclk
// Notes: Bus line idles recessive
`timescale 1ns/10ps
`default_nettype none
module cbtrf_msg_src (
  input wire logic aclk,
  output logic msg_valid,
  output logic [cbtrf_pkg::ID_W-1:0] msg_id,
  output logic can_rx
);
  initial begin
    msg_valid = 1'b0;
    msg_id = '0;
    can_rx = 1'b1;
  end
  // ==========================================================
  // Send one message
  task automatic send(input logic [cbtrf_pkg::ID_W-1:0] id);
    @(posedge aclk);
    msg_valid <= 1'b1;
    msg_id <= id;
    @(posedge aclk);
    msg_valid <= 1'b0;
    // Stale identifier must not look valid
    msg_id <= ~id;
  endtask : send
  // ==========================================================
  // Hold the bus line dominant for n cycles, then let it settle
  task automatic line_low(input int n);
    @(posedge aclk);
    can_rx <= 1'b0;
    repeat (n) @(posedge aclk);
    can_rx <= 1'b1;
    repeat (16) @(posedge aclk);
  endtask : line_low
endmodule : cbtrf_msg_src
`default_nettype wire

// File: verification/tb_cbtrf_core.sv
// Purpose: Self-checking bench for the timing, FIFO and filter block
// Assumes: Register answers come whenever the slave is ready
// Notes: Wake, high-water and quantum-tick pulses are counted on every rising edge
`timescale 1ns/10ps
`default_nettype none
module tb_cbtrf_core;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, msg_valid, can_rx;
  logic msg_stored, capture_trigger, high_water_event, wake_event;
  logic quantum_tick;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [2:0] store_index, jump_width_quanta;
  logic [7:0] quantum_clocks;
  logic [3:0] phase_two_quanta;
  logic [cbtrf_pkg::ID_W-1:0] msg_id;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int wakes = 0;
  int hwms = 0;
  int ticks = 0;
  cbtrf_core cbtrf_core_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .msg_valid, .msg_id, .can_rx, .msg_stored, .store_index,
    .capture_trigger, .high_water_event, .wake_event, .quantum_tick,
    .jump_width_quanta, .quantum_clocks, .phase_two_quanta);
  cbtrf_msg_src cbtrf_msg_src_i (.aclk, .msg_valid, .msg_id, .can_rx);
  initial forever #12.5 aclk = ~aclk;
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] a,
      input logic [31:0] m, input logic [31:0] exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
    chk(what, exp, rd & m);
  endtask : rchk
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle
  task automatic timing3(input logic [31:0] j, c, p);
    chk("jump", j, 32'(jump_width_quanta));
    chk("clocks", c, 32'(quantum_clocks));
    chk("phase2", p, 32'(phase_two_quanta));
  endtask : timing3
  // ==========================================================
  // Scenarios
  task automatic t_timing;
    int n;
    timing3(32'h1, 32'h2, 32'h0);
    wr(cbtrf_pkg::OFS_TIMING_A, 32'hFF);
    rchk("timing_a", cbtrf_pkg::OFS_TIMING_A, 32'hFF, 32'h0);
    wr(cbtrf_pkg::OFS_CONTROL, 32'h1);
    wr(cbtrf_pkg::OFS_TIMING_A, 32'hFF);
    wr(cbtrf_pkg::OFS_TIMING_C, 32'hFF);
    settle();
    timing3(32'h4, 32'h80, 32'h0);
    rchk("timing_c", cbtrf_pkg::OFS_TIMING_C, 32'hFF, 32'hC7);
    wr(cbtrf_pkg::OFS_TIMING_A, 32'h41);
    wr(cbtrf_pkg::OFS_CONTROL, 32'h9);
    settle();
    timing3(32'h2, 32'h4, 32'h8);
    // Eight cycles at four clocks per quantum hold exactly two ticks
    n = ticks;
    repeat (8) @(posedge aclk);
    #1;
    chk("ticks", 32'h2, 32'(ticks - n));
    rchk("unmapped", 8'h80, 32'hFFFFFFFF, 32'h0);
    chk("resp", 32'(cbtrf_pkg::RESP_SLVERR), 32'(rs));
  endtask : t_timing
  task automatic t_wake;
    cbtrf_msg_src_i.line_low(12);
    chk("wake_off", 32'h0, 32'(wakes));
    wr(cbtrf_pkg::OFS_TIMING_C, 32'h47);
    cbtrf_msg_src_i.line_low(4);
    chk("wake_short", 32'h0, 32'(wakes));
    cbtrf_msg_src_i.line_low(12);
    chk("wake_long", 32'h1, 32'(wakes));
  endtask : t_wake
  task automatic msg(input logic [28:0] id, input logic [31:0] s, i, c);
    cbtrf_msg_src_i.send(id);
    #1;
    chk("stored", s, 32'(msg_stored));
    chk("index", i, 32'(store_index));
    chk("capture", c, 32'(capture_trigger));
  endtask : msg
  task automatic t_fifo;
    // Two-deep ring: first store leaves one free, pointers wrap
    wr(cbtrf_pkg::OFS_BUF_DIR, 32'h1);
    wr(cbtrf_pkg::OFS_CONTROL, 32'h5);
    wr(cbtrf_pkg::OFS_CONTROL, 32'h4);
    wr(cbtrf_pkg::OFS_FILT_EN, 32'h4);
    wr(cbtrf_pkg::OFS_FILTER0 + 8'h08, 32'h0ABCDEF);
    wr(cbtrf_pkg::OFS_MASK0 + 8'h04, 32'hFF00);
    wr(cbtrf_pkg::OFS_IO_CTRL, 32'h13);
    msg(29'h0000CD00, 32'h1, 32'h0, 32'h1);
    msg(29'h0ABCDCEF, 32'h0, 32'h0, 32'h0);
    rchk("code", cbtrf_pkg::OFS_STATUS, 32'h1F, 32'h10);
    rchk("rptr", cbtrf_pkg::OFS_CONTROL, 32'hF0000, 32'h0);
    msg(29'h1FFFCDFF, 32'h1, 32'h1, 32'h1);
    chk("hwm", 32'h1, 32'(hwms));
    wr(cbtrf_pkg::OFS_FULL, 32'h1);
    rchk("rptr", cbtrf_pkg::OFS_CONTROL, 32'hF0000, 32'h10000);
    rchk("empty", cbtrf_pkg::OFS_STATUS, 32'h100, 32'h0);
    wr(cbtrf_pkg::OFS_FULL, 32'h2);
    rchk("empty", cbtrf_pkg::OFS_STATUS, 32'h100, 32'h100);
    wr(cbtrf_pkg::OFS_IO_CTRL, 32'h10);
    msg(29'h0000CD00, 32'h1, 32'h0, 32'h0);
    wr(cbtrf_pkg::OFS_CONTROL, 32'h0);
    msg(29'h0000CD00, 32'h1, 32'h1, 32'h0);
    chk("hwm", 32'h2, 32'(hwms));
  endtask : t_fifo
  task automatic t_depth;
    logic [5:0] dir [3] = '{6'h08, 6'h01, 6'h00};
    int dep [3] = '{5, 2, 8};
    for (int i = 0; i < 3; i++) begin
      wr(cbtrf_pkg::OFS_BUF_DIR, 32'(dir[i]));
      rchk("depth", cbtrf_pkg::OFS_STATUS, 32'h1E00, 32'(dep[i] << 9));
    end
  endtask : t_depth
  // ==========================================================
  // Run control
  task automatic complete_run;
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  always @(posedge aclk) begin
    if (wake_event === 1'b1) wakes++;
    if (high_water_event === 1'b1) hwms++;
    if (quantum_tick === 1'b1) ticks++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    t_timing();
    t_wake();
    t_fifo();
    t_depth();
    complete_run();
  end
endmodule : tb_cbtrf_core
`default_nettype wire
